//--- logic/sfcr_front_end.sv
/*
  sfcr_front_end: serial command front end of a serial flash. Frames each
  operation by chip select, shifts in opcode, address and dummy bytes,
  decodes the opcode and streams read data out on the serial output.
  Assumes an outside byte source that answers SRC_ADDR and SRC_KIND with
  SRC_DATA by the next clock, and outside control logic that carries out
  erase, program, protection, status and power-down work.
*/
// Behaviour
// - sample input on serial clock rise, drive output on its fall
// - every byte travels most significant bit first
// - unknown opcode starts nothing, input ignored until reselect
// - select lost before header complete means nothing is performed
// - three address bytes taken, top byte discarded
// - 4 KB and 32 KB erase blocks, 256-byte program pages
// - two read opcodes; fast one adds one dummy byte
// - read address advances one byte per delivered byte
// - read address wraps from top to zero without pause
// - select release mid-byte stops the read, output floats
// - 4 KB erase opcode with three address bytes
// - two 32 KB erase opcodes with three address bytes
// - three chip erase opcodes without address
// - page program opcode with address and data bytes
// - security register program opcode with address and data
// - security register read with address and two dummy bytes
// - identification read opcode without address
// - legacy identification read and power-down resume opcodes
// - deselected: input ignored, output floating
// - hold freezes clock and input, output floats
`timescale 1ns/1ns
module sfcr_front_end #(
  parameter int STAGES = sfcr_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic HOLD_N,
  output logic SO,
  output logic SO_OE,
  // read byte source
  output logic [1:0] SRC_KIND,
  output logic [15:0] SRC_ADDR,
  input wire logic [7:0] SRC_DATA,
  // command hand-off
  output logic OP_START,
  output logic [7:0] OP_CODE,
  output logic [15:0] OP_ADDR,
  output logic OP_END,
  output logic OP_COMPLETE,
  // incoming data bytes
  output logic DIN_STB,
  output logic [7:0] DIN_BYTE,
  output logic [15:0] DIN_ADDR
);

  if (STAGES < 2) begin : g_bad_stages
    $error("sfcr_front_end needs at least two synchroniser stages");
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DIN = 3'b100,
    ST_DOUT = 3'b101,
    ST_SKIP = 3'b110
  } sfcr_state_t;

  sfcr_bit_if lk ();

  sfcr_state_t state;
  sfcr_pkg::sfcr_cmd_t cmd;
  sfcr_pkg::sfcr_cmd_t dec;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [7:0] so_sh;
  logic out_live;
  logic din_any;
  logic byte_done;
  logic hdr_end;
  logic complete;

  // ----------------------------------------
  // link sampler
  // ----------------------------------------
  sfcr_link #(
    .STAGES(STAGES)
  ) u_link (
    .clk(CLK),
    .rst_n(RST_N),
    .cs_n(CS_N),
    .sck(SCK),
    .si(SI),
    .hold_n(HOLD_N),
    .bits(lk.src)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // state that follows the dummy bytes
  function automatic sfcr_state_t phase_state(input sfcr_pkg::sfcr_cmd_t c);
    sfcr_state_t s;
    s = ST_SKIP;
    if (c.phase == sfcr_pkg::PH_OUT) begin
      s = ST_DOUT;
    end else if (c.phase == sfcr_pkg::PH_IN) begin
      s = ST_DIN;
    end
    return s;
  endfunction : phase_state

  // state that follows the complete address
  function automatic sfcr_state_t body_state(input sfcr_pkg::sfcr_cmd_t c);
    return (c.dummy != 2'h0) ? ST_DUMMY : phase_state(c);
  endfunction : body_state

  // byte assembly and decode of the byte now closing
  always_comb begin
    next_sh = {sh[6:0], lk.bit_in};
    next_addr = {addr[14:0], lk.bit_in};
    byte_done = lk.rise && (bit_cnt == 3'h7);
    dec = sfcr_pkg::sfcr_decode(next_sh);
    hdr_end = byte_done && (((state == ST_OPC) && dec.known && !dec.addr3)
      || ((state == ST_ADDR) && (byte_cnt == 2'h0)));
  end

  // header done, byte aligned, and data given where data is due
  assign complete = cmd.known && (state inside {ST_DIN, ST_DOUT, ST_SKIP})
    && (bit_cnt == 3'h0) && ((cmd.phase != sfcr_pkg::PH_IN) || din_any);

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      cmd <= sfcr_pkg::CMD_NONE;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      sh <= 8'h00;
    end else if (lk.stop) begin
      state <= ST_IDLE;
    end else if (lk.start) begin
      state <= ST_OPC;
      cmd <= sfcr_pkg::CMD_NONE;
      bit_cnt <= 3'h0;
    end else if (lk.rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      sh <= next_sh;
      if (bit_cnt == 3'h7) begin
        unique case (state)
          ST_IDLE, ST_SKIP, ST_DIN, ST_DOUT: begin
            state <= state;
          end
          ST_OPC: begin
            cmd <= dec;
            byte_cnt <= 2'(sfcr_pkg::ADDR_BYTES - 1);
            if (!dec.known) begin
              state <= ST_SKIP;
            end else if (dec.addr3) begin
              state <= ST_ADDR;
            end else begin
              state <= body_state(dec);
            end
            if (dec.known && !dec.addr3) begin
              byte_cnt <= dec.dummy - 2'h1;
            end
          end
          ST_ADDR: begin
            if (byte_cnt == 2'h0) begin
              state <= body_state(cmd);
              byte_cnt <= cmd.dummy - 2'h1;
            end else begin
              byte_cnt <= byte_cnt - 2'h1;
            end
          end
          ST_DUMMY: begin
            if (byte_cnt == 2'h0) begin
              state <= phase_state(cmd);
            end else begin
              byte_cnt <= byte_cnt - 2'h1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // address counter
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr <= 16'h0000;
    end else if (lk.start) begin
      addr <= 16'h0000;
    end else if (lk.rise && (state == ST_ADDR)) begin
      addr <= next_addr;
    end else if (byte_done && (state == ST_DOUT)) begin
      addr <= addr + 16'h0001;
    end else if (byte_done && (state == ST_DIN)) begin
      addr <= {addr[15:8], addr[7:0] + 8'h01};
    end
  end

  assign SRC_ADDR = addr;
  assign SRC_KIND = cmd.src;

  // ----------------------------------------
  // command hand-off
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      OP_START <= 1'b0;
      OP_CODE <= 8'h00;
      OP_ADDR <= 16'h0000;
      OP_END <= 1'b0;
      OP_COMPLETE <= 1'b0;
    end else begin
      OP_START <= 1'b0;
      OP_END <= 1'b0;
      if (lk.start) begin
        OP_COMPLETE <= 1'b0;
      end
      if (byte_done && (state == ST_OPC) && dec.known) begin
        OP_START <= 1'b1;
        OP_CODE <= next_sh;
      end
      if (hdr_end) begin
        // block base for erase, plain start address for other addressed commands, zero without address
        if (state == ST_ADDR) begin
          OP_ADDR <= next_addr & cmd.mask;
        end else begin
          OP_ADDR <= 16'h0000;
        end
      end
      if (lk.stop && (state != ST_IDLE)) begin
        OP_END <= 1'b1;
        OP_COMPLETE <= complete;
      end
    end
  end

  // ----------------------------------------
  // incoming data bytes
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DIN_STB <= 1'b0;
      DIN_BYTE <= 8'h00;
      DIN_ADDR <= 16'h0000;
      din_any <= 1'b0;
    end else begin
      DIN_STB <= 1'b0;
      if (lk.start) begin
        din_any <= 1'b0;
      end else if (byte_done && (state == ST_DIN)) begin
        DIN_STB <= 1'b1;
        DIN_BYTE <= next_sh;
        DIN_ADDR <= addr;
        din_any <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  // a new byte is loaded on the first fall of each byte, then shifted
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SO <= 1'b0;
      so_sh <= 8'h00;
      out_live <= 1'b0;
    end else if (state != ST_DOUT) begin
      out_live <= 1'b0;
    end else if (lk.fall) begin
      out_live <= 1'b1;
      if (bit_cnt == 3'h0) begin
        SO <= SRC_DATA[7];
        so_sh <= {SRC_DATA[6:0], 1'b0};
      end else begin
        SO <= so_sh[7];
        so_sh <= {so_sh[6:0], 1'b0};
      end
    end
  end

  // output enable only while selected, not held, in a read data phase
  assign SO_OE = out_live && lk.sel && !lk.held && (state == ST_DOUT);

endmodule : sfcr_front_end

//--- pkg/sfcr_pkg.sv
/*
  sfcr_pkg: shared constants, opcodes, command attributes and the opcode
  decoder of the serial flash command and read front end.
  Assumes a 16-bit array address space and byte-wide serial transfers.
*/
package sfcr_pkg;

  // ----------------------------------------
  // array geometry and link constants
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int ADDR_BYTES = 3;
  localparam int BLK4_BYTES = 4096;
  localparam int BLK32_BYTES = 32768;
  localparam int PAGE_BYTES = 256;
  localparam logic [15:0] ARRAY_TOP = 16'hFFFF;
  localparam logic [15:0] MASK_NONE = 16'hFFFF;
  localparam logic [15:0] MASK_BLK4 = 16'(~(BLK4_BYTES - 1));
  localparam logic [15:0] MASK_BLK32 = 16'(~(BLK32_BYTES - 1));
  localparam int SLOW_READ_CLOCK_RATE_MHZ = 33;
  localparam int FULL_READ_CLOCK_RATE_MHZ = 70;
  localparam int SYNC_STAGES = 2;
  // synchroniser reset value, bits {hold_n, si, sck, cs_n}
  localparam logic [3:0] SYNC_RST = 4'h9;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K_A = 8'h52;
  localparam logic [7:0] OP_ERASE_32K_B = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_OLD = 8'h62;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h9B;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ID_READ = 8'h9F;
  localparam logic [7:0] OP_ID_READ_OLD = 8'h15;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RESUME = 8'hAB;

  // ----------------------------------------
  // command attributes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_NONE = 2'b00,
    PH_IN = 2'b01,
    PH_OUT = 2'b10
  } sfcr_phase_t;

  typedef enum logic [1:0] {
    SRC_ARRAY = 2'b00,
    SRC_OTP = 2'b01,
    SRC_STATUS = 2'b10,
    SRC_ID = 2'b11
  } sfcr_src_t;

  typedef struct packed {
    logic known;
    logic addr3;
    logic [1:0] dummy;
    sfcr_phase_t phase;
    sfcr_src_t src;
    logic [15:0] mask;
  } sfcr_cmd_t;

  localparam sfcr_cmd_t CMD_NONE = '{known: 1'b0, addr3: 1'b0, dummy: 2'h0,
    phase: PH_NONE, src: SRC_ARRAY, mask: 16'hFFFF};

  // maps an opcode onto its header layout and data phase
  function automatic sfcr_cmd_t sfcr_decode(input logic [7:0] op);
    sfcr_cmd_t d;
    d = CMD_NONE;
    d.known = 1'b1;
    case (op)
      OP_READ_FAST: begin
        d.addr3 = 1'b1;
        d.dummy = 2'h1;
        d.phase = PH_OUT;
      end
      OP_READ_SLOW: begin
        d.addr3 = 1'b1;
        d.phase = PH_OUT;
      end
      OP_ERASE_4K: begin
        d.addr3 = 1'b1;
        d.mask = MASK_BLK4;
      end
      OP_ERASE_32K_A, OP_ERASE_32K_B: begin
        d.addr3 = 1'b1;
        d.mask = MASK_BLK32;
      end
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_CHIP_ERASE_OLD: d.mask = MASK_NONE;
      OP_PROGRAM, OP_OTP_PROGRAM: begin
        d.addr3 = 1'b1;
        d.phase = PH_IN;
      end
      OP_OTP_READ: begin
        d.addr3 = 1'b1;
        d.dummy = 2'h2;
        d.phase = PH_OUT;
        d.src = SRC_OTP;
      end
      OP_STATUS_READ: begin
        d.phase = PH_OUT;
        d.src = SRC_STATUS;
      end
      OP_STATUS_WRITE: d.phase = PH_IN;
      OP_ID_READ, OP_ID_READ_OLD: begin
        d.phase = PH_OUT;
        d.src = SRC_ID;
      end
      OP_WRITE_EN, OP_WRITE_DIS, OP_POWER_DOWN, OP_RESUME: d.mask = MASK_NONE;
      default: d = CMD_NONE;
    endcase
    return d;
  endfunction : sfcr_decode

endpackage : sfcr_pkg

//--- pkg/sfcr_bit_if.sv
/*
  sfcr_bit_if: serial bit events passed from the link sampler to the
  command sequencer. All signals are on the system clock.
*/
`timescale 1ns/1ns
interface sfcr_bit_if;
  logic sel;
  logic held;
  logic rise;
  logic fall;
  logic bit_in;
  logic start;
  logic stop;
  modport src (output sel, held, rise, fall, bit_in, start, stop);
  modport dst (input sel, held, rise, fall, bit_in, start, stop);
endinterface : sfcr_bit_if

//--- logic/sfcr_link.sv
/*
  sfcr_link: synchronises the serial pins to the system clock and turns
  them into select, hold and clock-edge events.
  Assumes the serial clock is several times slower than the system clock.
*/
`timescale 1ns/1ns
module sfcr_link #(
  parameter int STAGES = sfcr_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  // bit events
  sfcr_bit_if.src bits
);

  if (STAGES < 2) begin : g_bad_stages
    $error("sfcr_link needs at least two synchroniser stages");
  end

  logic [3:0] chain [STAGES];
  logic [3:0] pin;
  logic sck_d;
  logic cs_d;
  logic held;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        chain[i] <= sfcr_pkg::SYNC_RST;
      end
    end else begin
      chain[0] <= {hold_n, si, sck, cs_n};
      for (int i = 1; i < STAGES; i++) begin
        chain[i] <= chain[i-1];
      end
    end
  end

  assign pin = chain[STAGES-1];

  // edge history of clock and select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sck_d <= pin[1];
      cs_d <= pin[0];
    end
  end

  // hold starts only while selected with the clock low; it ends then or at deselect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 1'b0;
    end else if (pin[0]) begin
      held <= 1'b0;
    end else if (!pin[1]) begin
      held <= !pin[3];
    end
  end

  // edges count only while selected and not held; either idle level works
  assign bits.sel = !pin[0];
  assign bits.held = held;
  assign bits.rise = !pin[0] && !held && pin[1] && !sck_d;
  assign bits.fall = !pin[0] && !held && !pin[1] && sck_d;
  assign bits.bit_in = pin[2];
  assign bits.start = cs_d && !pin[0];
  assign bits.stop = !cs_d && pin[0];

endmodule : sfcr_link

//--- sim/sfcr_front_end_checker.sv
/*
  sfcr_checker: port timing checks for the front end.
  Assumes it is bound onto every sfcr_front_end instance.
*/
`timescale 1ns/1ns
module sfcr_checker #(
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic HOLD_N,
  input wire logic SO_OE,
  // hand-off
  input wire logic [15:0] SRC_ADDR,
  input wire logic OP_START,
  input wire logic [7:0] OP_CODE,
  input wire logic [15:0] OP_ADDR,
  input wire logic OP_END,
  input wire logic DIN_STB
);
  // decoded attributes of the last opcode handed off
  sfcr_pkg::sfcr_cmd_t op_dec;
  assign op_dec = sfcr_pkg::sfcr_decode(OP_CODE);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  desel_float_a: assert property ($rose(CS_N) |-> ##[1:5] !SO_OE)
    else $error("output driven after deselect");
  oe_rise_a: assert property ($rose(SO_OE) |-> !CS_N && HOLD_N)
    else $error("output enabled while idle or held");
  hold_float_a: assert property ((!HOLD_N && !SCK) [*4] |-> !SO_OE)
    else $error("output driven during hold");
  oe_read_a: assert property (SO_OE |->
    op_dec.phase == sfcr_pkg::PH_OUT)
    else $error("output driven outside a read");
  din_kind_a: assert property (DIN_STB |->
    op_dec.phase == sfcr_pkg::PH_IN)
    else $error("data byte strobe for a command without data");
  start_known_a: assert property (OP_START |->
    op_dec.known ##1 !OP_START [*8])
    else $error("bad start pulse");
  end_pulse_a: assert property (OP_END |-> CS_N ##1 !OP_END)
    else $error("bad end pulse");
  blk4_mask_a: assert property ($changed(OP_ADDR) && OP_CODE == 8'h20 |->
    OP_ADDR[11:0] == 12'h000)
    else $error("small block address not aligned");
  blk32_mask_a: assert property ($changed(OP_ADDR) &&
    (OP_CODE == 8'h52 || OP_CODE == 8'hD8) |-> OP_ADDR[14:0] == 15'h0000)
    else $error("large block address not aligned");
  addr_step_a: assert property (SO_OE && $past(SO_OE) && $changed(SRC_ADDR) |->
    SRC_ADDR == $past(SRC_ADDR) + 16'h0001)
    else $error("read address did not step by one");
  cover property ($rose(SO_OE));
  cover property (DIN_STB);
  cover property ($fell(SO_OE) && !HOLD_N);
endmodule : sfcr_checker
bind sfcr_front_end sfcr_checker #(.STAGES(STAGES)) chk (.CLK(CLK), .RST_N(RST_N),
  .CS_N(CS_N), .SCK(SCK), .HOLD_N(HOLD_N), .SO_OE(SO_OE), .SRC_ADDR(SRC_ADDR),
  .OP_START(OP_START), .OP_CODE(OP_CODE), .OP_ADDR(OP_ADDR), .OP_END(OP_END),
  .DIN_STB(DIN_STB));

//--- sim/sfcr_host.sv
/*
  sfcr_host: behavioural serial bus master for the front end pins.
  Assumes a 10 MHz reference clock; half a serial bit is four cycles.
*/
`timescale 1ns/1ns
module sfcr_host (
  // timing reference
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so
);
  logic mode = 1'b0; // idle clock level
  logic hold_bit = 1'b0; // pause inside the next byte
  // idle pin levels
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // half a bit, landing just after a clock edge
  task automatic half();
    repeat (4) @(posedge clk); // 800 ns serial clock, below the no-dummy read limit
    #5;
  endtask : half
  // select with the clock at its idle level
  task automatic sel();
    sck = mode;
    half();
    cs_n = 1'b0;
    half();
  endtask : sel
  // n bits each way msb first, input set at the fall, output read before it
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si = tx[i];
      if (hold_bit && i == 3) begin
        hold_n = 1'b0; // pause with clock low, clock pulsed meanwhile
        half();
        sck = 1'b1;
        half();
        sck = 1'b0;
        half();
        hold_n = 1'b1;
      end
      half();
      sck = 1'b1;
      half();
      rx[i] = so;
    end
    hold_bit = 1'b0;
  endtask : xfer
  // release: clock back to idle, then deselect with the data line left wandering
  task automatic desel();
    half();
    sck = mode;
    half();
    cs_n = 1'b1;
    si = ~si;
  endtask : desel
endmodule : sfcr_host

//--- sim/sfcr_front_end_tb.sv
/*
  sfcr_front_end_tb: self-checking bench for the serial command front end.
  Assumes the host model and a combinational byte source in the bench.
*/
`timescale 1ns/1ns
module sfcr_front_end_tb;
  `define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin num_errors++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
  typedef struct {logic [7:0] op; int na, nd, ni, no; logic [1:0] k; logic [15:0] m;} sfcr_tc_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sck, si, hold_n, so, so_oe, so_pin, op_start, op_end, op_complete, din_stb;
  logic [1:0] src_kind;
  logic [15:0] src_addr, op_addr, din_addr, a;
  logic [7:0] src_data, op_code, din_byte;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int starts = 0;
  int oe_seen = 0;
  int din_n = 0;
  sfcr_tc_t tbl[19] = '{'{8'h03, 3, 0, 0, 3, 0, 16'hFFFF}, '{8'h0B, 3, 1, 0, 3, 0, 16'hFFFF},
    '{8'h77, 3, 2, 0, 3, 1, 16'hFFFF}, '{8'h20, 3, 0, 0, 0, 0, 16'hF000},
    '{8'h52, 3, 0, 0, 0, 0, 16'h8000}, '{8'hD8, 3, 0, 0, 0, 0, 16'h8000},
    '{8'h60, 0, 0, 0, 0, 0, 16'h0}, '{8'hC7, 0, 0, 0, 0, 0, 16'h0}, '{8'h62, 0, 0, 0, 0, 0, 16'h0},
    '{8'h06, 0, 0, 0, 0, 0, 16'h0}, '{8'h04, 0, 0, 0, 0, 0, 16'h0}, '{8'hB9, 0, 0, 0, 0, 0, 16'h0},
    '{8'hAB, 0, 0, 0, 0, 0, 16'h0}, '{8'h02, 3, 0, 3, 0, 0, 16'hFFFF},
    '{8'h9B, 3, 0, 2, 0, 0, 16'hFFFF}, '{8'h01, 0, 0, 1, 0, 0, 16'h0},
    '{8'h05, 0, 0, 0, 2, 2, 16'h0}, '{8'h9F, 0, 0, 0, 4, 3, 16'h0}, '{8'h15, 0, 0, 0, 2, 3, 16'h0}};
  // byte source contents
  function automatic logic [7:0] exp_byte(input logic [1:0] k, input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ {6'h00, k};
  endfunction : exp_byte
  assign src_data = exp_byte(src_kind, src_addr);
  // released output line shows the inverse of its last value
  assign so_pin = so_oe ? so : ~so;
  // clock
  initial begin
    forever #50 clk = ~clk;
  end
  // event counters and hang guard
  always @(posedge clk) begin
    cycles++;
    if (op_start === 1'b1) starts++;
    if (so_oe === 1'b1) oe_seen++;
    if (din_stb === 1'b1) din_n++;
    if (cycles == 60000) begin
      num_errors++;
      final_report();
    end
  end
  sfcr_front_end #(.STAGES(2)) uut (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck), .SI(si),
    .HOLD_N(hold_n), .SO(so), .SO_OE(so_oe), .SRC_KIND(src_kind), .SRC_ADDR(src_addr),
    .SRC_DATA(src_data), .OP_START(op_start), .OP_CODE(op_code), .OP_ADDR(op_addr),
    .OP_END(op_end), .OP_COMPLETE(op_complete), .DIN_STB(din_stb), .DIN_BYTE(din_byte),
    .DIN_ADDR(din_addr));
  sfcr_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so_pin));
  // verdict
  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // wait for the end pulse, bounded
  task automatic wait_end();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #5;
      n++;
    end while (op_end !== 1'b1 && n < 40);
    `CHK("end pulse", 1'b1, op_end)
  endtask : wait_end
  // one whole command from the table
  task automatic run(input sfcr_tc_t t, input logic [15:0] ad);
    logic [7:0] rx, d;
    logic [15:0] b;
    int s0, d0;
    s0 = starts;
    d0 = din_n;
    oe_seen = 0;
    b = (t.na > 0) ? ad : 16'h0000;
    host.mode = 1'($urandom % 2);
    host.sel();
    host.xfer(t.op, rx, 8);
    if (t.na > 0) begin
      host.xfer(8'($urandom), rx, 8);
      host.xfer(ad[15:8], rx, 8);
      host.xfer(ad[7:0], rx, 8);
    end
    repeat (t.nd) host.xfer(8'($urandom), rx, 8);
    for (int j = 0; j < t.ni; j++) begin
      d = 8'($urandom);
      host.xfer(d, rx, 8);
    end
    for (int j = 0; j < t.no; j++) begin
      host.hold_bit = (j == 1);
      host.xfer(8'($urandom), rx, 8);
      `CHK("read byte", exp_byte(t.k, 16'(b + j)), rx)
    end
    host.desel();
    wait_end();
    `CHK("start count", 1, starts - s0)
    `CHK("opcode", t.op, op_code)
    `CHK("op address", b & t.m, op_addr)
    `CHK("complete", 1'b1, op_complete)
    `CHK("data count", t.ni, din_n - d0)
    `CHK("output idle", 1'b0, so_oe)
    if (t.no == 0) `CHK("no output", 0, oe_seen)
    if (t.ni > 0) `CHK("data byte", d, din_byte)
    if (t.ni > 0 && t.na > 0) `CHK("data addr", {b[15:8], 8'(b[7:0] + t.ni - 1)}, din_addr)
    host.half();
  endtask : run
  // cut-short or unknown command: nb whole bytes then half a byte
  task automatic cut(input logic [7:0] op, input int nb, ns, oe);
    logic [7:0] rx;
    int s0;
    s0 = starts;
    oe_seen = 0;
    host.sel();
    host.xfer(op, rx, 8);
    repeat (nb) host.xfer(8'($urandom), rx, 8);
    host.xfer(8'h03, rx, 4);
    host.desel();
    wait_end();
    `CHK("cut start", ns, starts - s0)
    `CHK("cut complete", 1'b0, op_complete)
    `CHK("cut output", oe, oe_seen > 0)
    host.half();
  endtask : cut
  // main sequence
  initial begin
    void'($urandom(55));
    repeat (16) @(posedge clk);
    #5;
    rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #5;
    for (int r = 0; r < 2; r++) begin
      foreach (tbl[i]) begin
        a = (r == 0) ? 16'($urandom) : 16'hFFFE;
        run(tbl[i], a);
      end
    end
    cut(8'hFF, 6, 0, 0);
    cut(8'h03, 2, 1, 0);
    cut(8'h20, 1, 1, 0);
    cut(8'h03, 4, 1, 1);
    final_report();
  end
endmodule : sfcr_front_end_tb
